// >>> rtl/terminal_function_holding_regs.sv
// terminal function holding register bank with status comparators
// assumes network requests and drive values arrive on clk_sys_i;
// input terminal pins are asynchronous and are synchronised here
`timescale 1ns/1ps
module terminal_function_holding_regs #(
    parameter int in_count = 5,
    parameter int out_count = 3
) (
    input logic clk_sys_i,
    input logic rst_i,
    input term_bank_pkg::net_req_type net_req_i,
    output term_bank_pkg::net_rsp_type net_rsp_o,
    input logic local_wr_i,
    input logic [2:0] local_sel_i,
    input term_bank_pkg::word_type local_data_i,
    input logic [in_count-1:0] in_term_pin_i,
    output logic [in_count-1:0] in_term_active_o,
    input logic [out_count-1:0] out_term_state_i,
    output logic [out_count-1:0] out_term_pin_o,
    input term_bank_pkg::drive_meas_type meas_i,
    output term_bank_pkg::word_type analog_monitor_output_o,
    output logic quick_start_o,
    output term_bank_pkg::word_type [in_count-1:0] in_func_o,
    output term_bank_pkg::word_type [out_count-1:0] out_func_o,
    output term_bank_pkg::drive_status_type status_o,
    output term_bank_pkg::serial_cfg_type serial_cfg_o
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (in_count != term_bank_pkg::in_term_count ||
        out_count != term_bank_pkg::out_term_count) begin : g_chk
        $error("terminal counts must match the register map");
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        term_bank_pkg::word_type [term_bank_pkg::reg_count-1:0] hold;
        logic [in_count-1:0] in_meta;
        logic [in_count-1:0] in_sync;
        logic [in_count-1:0] in_act;
        logic [out_count-1:0] out_pin;
        term_bank_pkg::net_rsp_type rsp;
        term_bank_pkg::word_type mon;
        logic stage2;
    } state_type;

    state_type st_ff;
    state_type nxt_st;

    logic hit;
    logic net_ok;
    term_bank_pkg::hold_reg_type idx;
    logic [in_count-1:0] in_pol;
    logic [out_count-1:0] out_pol;
    term_bank_pkg::word_type deviation;
    logic win_high;
    logic win_low;
    logic ovl_hit;
    logic acc_hit;
    logic dec_hit;
    logic dev_hit;

    // shorthand views of the threshold and monitor source registers
    term_bank_pkg::word_type thr_ovl;
    term_bank_pkg::word_type thr_acc;
    term_bank_pkg::word_type thr_dec;
    term_bank_pkg::word_type thr_dev;
    term_bank_pkg::word_type thr_up;
    term_bank_pkg::word_type thr_lo;
    term_bank_pkg::word_type mon_sel;

    assign thr_ovl = st_ff.hold[term_bank_pkg::overload_threshold];
    assign thr_acc = st_ff.hold[term_bank_pkg::accel_arrival_threshold];
    assign thr_dec = st_ff.hold[term_bank_pkg::decel_arrival_threshold];
    assign thr_dev = st_ff.hold[term_bank_pkg::loop_deviation_threshold];
    assign thr_up = st_ff.hold[term_bank_pkg::feedback_window_upper];
    assign thr_lo = st_ff.hold[term_bank_pkg::feedback_window_lower];
    assign mon_sel = st_ff.hold[term_bank_pkg::analog_monitor_source];

    ////////////////////////////////////////////////////////////////////////
    // address decode and polarity lookup

    // match the request address against the whole map
    always_comb begin
        hit = 1'b0;
        idx = term_bank_pkg::quick_start_enable;
        for (int i = 0; i < term_bank_pkg::reg_count; i++) begin
            if (net_req_i.addr == term_bank_pkg::hold_addr[i]) begin
                hit = 1'b1;
                idx = term_bank_pkg::hold_reg_type'(i[4:0]);
            end
        end
    end

    // serial registers decode but stay out of network reach
    assign net_ok = hit &&
        int'(idx) < term_bank_pkg::net_reg_count;

    // break-contact terminals invert their sense
    always_comb begin
        for (int i = 0; i < in_count; i++) begin
            in_pol[i] = st_ff.hold[int'(term_bank_pkg::input_term1_polarity)
                + i] == term_bank_pkg::pol_break;
        end
        out_pol[0] = st_ff.hold[term_bank_pkg::output_term11_polarity]
            == term_bank_pkg::pol_break;
        out_pol[1] = st_ff.hold[term_bank_pkg::output_term12_polarity]
            == term_bank_pkg::pol_break;
        out_pol[2] = st_ff.hold[term_bank_pkg::alarm_relay_polarity]
            == term_bank_pkg::pol_break;
    end

    // absolute loop error
    assign deviation = (meas_i.setpoint > meas_i.feedback) ?
        meas_i.setpoint - meas_i.feedback :
        meas_i.feedback - meas_i.setpoint;

    ////////////////////////////////////////////////////////////////////////
    // status comparators

    // current scaled so that 10000 is rated current
    threshold_cmp #(.width(16), .mode(term_bank_pkg::cmp_gt)) u_ovl (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .enable_i(1'b1),
        .value_i(meas_i.current), .limit_i(thr_ovl), .hit_o(ovl_hit)
    );

    threshold_cmp #(.width(16), .mode(term_bank_pkg::cmp_ge)) u_acc (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .enable_i(meas_i.accel),
        .value_i(meas_i.freq), .limit_i(thr_acc), .hit_o(acc_hit)
    );

    threshold_cmp #(.width(16), .mode(term_bank_pkg::cmp_le)) u_dec (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .enable_i(meas_i.decel),
        .value_i(meas_i.freq), .limit_i(thr_dec), .hit_o(dec_hit)
    );

    threshold_cmp #(.width(16), .mode(term_bank_pkg::cmp_gt)) u_dev (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .enable_i(1'b1),
        .value_i(deviation), .limit_i(thr_dev), .hit_o(dev_hit)
    );

    threshold_cmp #(.width(16), .mode(term_bank_pkg::cmp_gt)) u_up (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .enable_i(1'b1),
        .value_i(meas_i.feedback), .limit_i(thr_up), .hit_o(win_high)
    );

    threshold_cmp #(.width(16), .mode(term_bank_pkg::cmp_lt)) u_lo (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .enable_i(1'b1),
        .value_i(meas_i.feedback), .limit_i(thr_lo), .hit_o(win_low)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st = st_ff;
        // network answer: one cycle pulse per request
        nxt_st.rsp.ack = net_req_i.req;
        nxt_st.rsp.exc = term_bank_pkg::exc_none;
        if (net_req_i.req) begin
            if (!net_ok) begin
                nxt_st.rsp.exc = term_bank_pkg::exc_bad_addr;
            end else if (!net_req_i.we) begin
                nxt_st.rsp.rdata = st_ff.hold[idx];
            end else if (!term_bank_pkg::value_ok(idx, net_req_i.wdata)) begin
                nxt_st.rsp.exc = term_bank_pkg::exc_bad_value;
            end else begin
                nxt_st.hold[idx] = net_req_i.wdata;
                nxt_st.rsp.rdata = net_req_i.wdata;
            end
        end
        // keypad side edits of the serial set
        if (local_wr_i && 32'(local_sel_i) <
            term_bank_pkg::reg_count - term_bank_pkg::net_reg_count) begin
            nxt_st.hold[term_bank_pkg::net_reg_count + int'(local_sel_i)] =
                local_data_i;
        end
        // two-stage pin synchroniser, then polarity
        nxt_st.in_meta = in_term_pin_i;
        nxt_st.in_sync = st_ff.in_meta;
        nxt_st.in_act = st_ff.in_sync ^ in_pol;
        nxt_st.out_pin = out_term_state_i ^ out_pol;
        // monitor source select
        if (mon_sel == term_bank_pkg::mon_current) begin
            nxt_st.mon = meas_i.current;
        end else begin
            nxt_st.mon = meas_i.speed;
        end
        // feedback window, upper limit wins if both trip
        if (win_high) begin
            nxt_st.stage2 = 1'b0;
        end else if (win_low) begin
            nxt_st.stage2 = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_ff <= '0;
            for (int i = 0; i < term_bank_pkg::reg_count; i++) begin
                st_ff.hold[i] <= term_bank_pkg::hold_reset_value;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign net_rsp_o = st_ff.rsp;
    assign in_term_active_o = st_ff.in_act;
    assign out_term_pin_o = st_ff.out_pin;
    assign analog_monitor_output_o = st_ff.mon;
    assign quick_start_o = st_ff.hold[term_bank_pkg::quick_start_enable]
        == term_bank_pkg::code_on;
    assign in_func_o = st_ff.hold[term_bank_pkg::input_term5_function:
        term_bank_pkg::input_term1_function];
    assign out_func_o = st_ff.hold[term_bank_pkg::alarm_relay_function:
        term_bank_pkg::output_term11_function];
    assign serial_cfg_o = st_ff.hold[term_bank_pkg::reg_count-1:
        term_bank_pkg::net_reg_count];
    assign status_o.overload = ovl_hit;
    assign status_o.accel_arrive = acc_hit;
    assign status_o.decel_arrive = dec_hit;
    assign status_o.deviation = dev_hit;
    assign status_o.stage2 = st_ff.stage2;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    logic wr_ovl;
    assign wr_ovl = net_req_i.req && net_req_i.we && net_req_i.addr ==
        term_bank_pkg::hold_addr[term_bank_pkg::overload_threshold];

    a_quick_start_out: assert property (
        net_req_i.req && net_req_i.we && net_req_i.wdata ==
        term_bank_pkg::code_on && net_req_i.addr ==
        term_bank_pkg::hold_addr[term_bank_pkg::quick_start_enable]
        |=> quick_start_o)
        else $error("quick start not enabled by write of 01");

    a_in_polarity: assert property (
        $stable(in_pol[0]) [*3] |-> in_term_active_o[0] ==
        ($past(in_term_pin_i[0], 3) ^ in_pol[0]))
        else $error("input terminal polarity not applied");

    a_monitor_route: assert property (
        ##1 analog_monitor_output_o == ($past(mon_sel) ==
        term_bank_pkg::mon_current ? $past(meas_i.current) :
        $past(meas_i.speed)))
        else $error("monitor output from wrong source");

    a_overload_range: assert property (
        wr_ovl && net_req_i.wdata > term_bank_pkg::overload_max
        |=> net_rsp_o.exc == term_bank_pkg::exc_bad_value &&
        $stable(thr_ovl))
        else $error("overload threshold above range accepted");

    a_overload_flag: assert property (
        ##1 status_o.overload == ($past(meas_i.current) >
        $past(thr_ovl)))
        else $error("overload flag wrong");

    a_accel_arrive: assert property (
        meas_i.accel && meas_i.freq >= thr_acc |=> status_o.accel_arrive)
        else $error("accel arrival missed");

    a_decel_arrive: assert property (
        !meas_i.decel |=> !status_o.decel_arrive)
        else $error("decel arrival outside deceleration");

    a_deviation_flag: assert property (
        deviation <= thr_dev |=> !status_o.deviation)
        else $error("deviation flag inside limit");

    a_window_off: assert property (
        meas_i.feedback > thr_up ##1 $stable(thr_up) |=> !status_o.stage2)
        else $error("stage two still on above upper");

    a_window_on: assert property (
        meas_i.feedback < thr_lo && meas_i.feedback <= thr_up ##1
        $stable(thr_lo) && $stable(thr_up) |=> status_o.stage2)
        else $error("stage two still off below lower");

    a_serial_hidden: assert property (
        net_req_i.req && hit && !net_ok |=> net_rsp_o.ack &&
        net_rsp_o.exc == term_bank_pkg::exc_bad_addr &&
        ($stable(serial_cfg_o) || $past(local_wr_i)))
        else $error("serial register reached from network");

    a_answer_pulse: assert property (
        net_req_i.req |=> net_rsp_o.ack ##1 (net_rsp_o.ack ==
        $past(net_req_i.req)))
        else $error("network answer not one cycle after request");

    c_write_ok: cover property (
        net_req_i.req && net_req_i.we ##1
        net_rsp_o.exc == term_bank_pkg::exc_none);
    c_write_reject: cover property (
        net_req_i.req ##1 net_rsp_o.exc == term_bank_pkg::exc_bad_value);
    c_stage2_cycle: cover property (
        status_o.stage2 ##[1:20] !status_o.stage2);

endmodule : terminal_function_holding_regs

// >>> include/term_bank_pkg.sv
// holding register map, value ranges and carriers of the terminal bank
// assumes 16-bit holding registers addressed by plain register number
package term_bank_pkg;

    typedef logic [15:0] word_type;

    // map size: network registers first, local-only serial set last
    localparam int reg_count = 31;
    localparam int net_reg_count = 24;
    localparam int in_term_count = 5;
    localparam int out_term_count = 3;

    typedef enum logic [4:0] {
        quick_start_enable,
        input_term1_function, input_term2_function, input_term3_function,
        input_term4_function, input_term5_function,
        input_term1_polarity, input_term2_polarity, input_term3_polarity,
        input_term4_polarity, input_term5_polarity,
        output_term11_function, output_term12_function,
        alarm_relay_function, analog_monitor_source,
        output_term11_polarity, output_term12_polarity,
        alarm_relay_polarity, overload_threshold,
        accel_arrival_threshold, decel_arrival_threshold,
        loop_deviation_threshold, feedback_window_upper,
        feedback_window_lower,
        serial_baud_select, serial_node_number, serial_parity_select,
        serial_stop_bits, serial_error_action, serial_error_timeout,
        serial_wait_time
    } hold_reg_type;

    // holding register numbers in enum order
    localparam word_type hold_addr [reg_count] = '{
        16'h10f9, 16'h1103, 16'h1104, 16'h1105, 16'h1106, 16'h1107,
        16'h110b, 16'h110c, 16'h110d, 16'h110e, 16'h110f,
        16'h1114, 16'h1115, 16'h1119, 16'h111b,
        16'h111d, 16'h111e, 16'h1122, 16'h1124, 16'h1126, 16'h1128,
        16'h1129, 16'h112e, 16'h112f,
        16'h1138, 16'h1139, 16'h113b, 16'h113c, 16'h113d, 16'h113e,
        16'h113f};

    // option codes and scales
    localparam word_type code_off = 16'h0000;
    localparam word_type code_on = 16'h0001;
    localparam word_type pol_make = 16'h0000;
    localparam word_type pol_break = 16'h0001;
    localparam word_type mon_speed = 16'h0000;
    localparam word_type mon_current = 16'h0001;
    localparam word_type rated_current_scale = 16'h2710;
    localparam word_type overload_max = 16'(2 * rated_current_scale);
    localparam word_type freq_max = 16'h0fa0;
    localparam word_type pct_max = 16'h03e8;
    localparam word_type out_func_max = 16'h0009;
    localparam word_type hold_reset_value = 16'h0000;

    // upper bound per network register (input functions use a code set)
    localparam word_type hold_max [net_reg_count] = '{
        code_on, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
        code_on, code_on, code_on, code_on, code_on,
        out_func_max, out_func_max, out_func_max, code_on,
        code_on, code_on, code_on, overload_max, freq_max, freq_max,
        pct_max, pct_max, pct_max};

    // answer codes of the network port
    localparam logic [7:0] exc_none = 8'h00;
    localparam logic [7:0] exc_bad_addr = 8'h02;
    localparam logic [7:0] exc_bad_value = 8'h03;

    typedef enum logic [1:0] {cmp_gt, cmp_ge, cmp_lt, cmp_le} cmp_mode_type;

    typedef struct packed {
        logic req;
        logic we;
        word_type addr;
        word_type wdata;
    } net_req_type;

    typedef struct packed {
        logic ack;
        logic [7:0] exc;
        word_type rdata;
    } net_rsp_type;

    typedef struct packed {
        word_type speed;
        word_type current;
        word_type freq;
        logic accel;
        logic decel;
        word_type setpoint;
        word_type feedback;
    } drive_meas_type;

    typedef struct packed {
        logic overload;
        logic accel_arrive;
        logic decel_arrive;
        logic deviation;
        logic stage2;
    } drive_status_type;

    // msb first: wait time down to baud select
    typedef struct packed {
        word_type wait_time;
        word_type error_timeout;
        word_type error_action;
        word_type stop_bits;
        word_type parity;
        word_type node;
        word_type baud;
    } serial_cfg_type;

    // legal input terminal function codes
    function automatic logic in_func_ok(word_type v);
        unique case (v)
            16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
            16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h000b, 16'h000c,
            16'h000d, 16'h000f, 16'h0010, 16'h0012, 16'h0013, 16'h0014,
            16'h0015, 16'h0016, 16'h0017, 16'h0018, 16'h001b, 16'h001c,
            16'h001d, 16'h001f, 16'h0032, 16'h0033, 16'h00ff: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : in_func_ok

    // range check of a network write
    function automatic logic value_ok(hold_reg_type r, word_type v);
        if (r >= input_term1_function && r <= input_term5_function) begin
            return in_func_ok(v);
        end
        return v <= hold_max[int'(r)];
    endfunction : value_ok

endpackage : term_bank_pkg

// >>> rtl/threshold_cmp.sv
// registered threshold comparator for the drive status flags
// assumes value and limit come from logic on the same clock
`timescale 1ns/1ps
module threshold_cmp #(
    parameter int width = 16,
    parameter term_bank_pkg::cmp_mode_type mode = term_bank_pkg::cmp_gt
) (
    input logic clk_sys_i,
    input logic rst_i,
    input logic enable_i,
    input logic [width-1:0] value_i,
    input logic [width-1:0] limit_i,
    output logic hit_o
);

    if (width < 1) begin : g_chk
        $error("threshold_cmp: width must be positive");
    end

    typedef struct packed {
        logic hit;
    } state_type;

    state_type st_ff;
    state_type nxt_st;

    // compare in the chosen sense, gated by the enable
    always_comb begin
        nxt_st = st_ff;
        unique case (mode)
            term_bank_pkg::cmp_gt: nxt_st.hit = value_i > limit_i;
            term_bank_pkg::cmp_ge: nxt_st.hit = value_i >= limit_i;
            term_bank_pkg::cmp_lt: nxt_st.hit = value_i < limit_i;
            term_bank_pkg::cmp_le: nxt_st.hit = value_i <= limit_i;
        endcase
        nxt_st.hit = nxt_st.hit & enable_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hit_o = st_ff.hit;

endmodule : threshold_cmp

// >>> dv/net_master_model.sv
// network master model issuing holding register requests one at a time
// assumes the bank answers on the same clock, one cycle after the request
`timescale 1ns/1ps
module net_master_model (
    input logic clk_sys_i,
    output term_bank_pkg::net_req_type net_req_o,
    input term_bank_pkg::net_rsp_type net_rsp_i
);
    initial net_req_o = '0;

    ////////////////////////////////////////////////////////////////////////
    // random idle gap, one request pulse, bounded wait for the answer
    task xfer(input logic we, input term_bank_pkg::word_type a, d,
              output logic [7:0] exc, output term_bank_pkg::word_type rd,
              output logic tmo);
        int n;
        n = 0;
        repeat ($urandom % 3) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #1;
        net_req_o = '{1'b1, we, a, d};
        @(posedge clk_sys_i);
        #1;
        // released lines show the inverse of the last request
        net_req_o = '{1'b0, ~we, ~a, ~d};
        while (net_rsp_i.ack !== 1'b1 && n < 4) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        exc = net_rsp_i.exc;
        rd = net_rsp_i.rdata;
        tmo = (n == 4);
    endtask : xfer
endmodule : net_master_model

// >>> dv/terminal_function_holding_regs_tb_top.sv
// self-checking bench of the terminal holding register bank
// assumes the master model drives the network port of the bank
`timescale 1ns/1ps
module terminal_function_holding_regs_tb_top;
    typedef term_bank_pkg::word_type w_type;
    logic clk_sys_i;
    logic rst_i;
    term_bank_pkg::net_req_type req;
    term_bank_pkg::net_rsp_type rsp;
    logic lwr;
    logic [2:0] lsel;
    w_type ldat, mon, rd, t, ha;
    w_type [2:0] out_func;
    logic [4:0] in_pin, in_act;
    logic [2:0] out_st, out_pin;
    term_bank_pkg::drive_meas_type meas;
    logic qs, tmo;
    w_type [4:0] in_func;
    term_bank_pkg::drive_status_type st;
    term_bank_pkg::serial_cfg_type scfg, prev;
    logic [7:0] exc;
    int error_cnt = 0;
    int n_compared = 0;
    w_type shadow [24];
    w_type fc [6] = '{16'h0000, 16'h0009, 16'h000b, 16'h001f, 16'h0033,
                      16'h00ff};

    terminal_function_holding_regs uut (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .net_req_i(req), .net_rsp_o(rsp),
        .local_wr_i(lwr), .local_sel_i(lsel), .local_data_i(ldat),
        .in_term_pin_i(in_pin), .in_term_active_o(in_act),
        .out_term_state_i(out_st), .out_term_pin_o(out_pin),
        .meas_i(meas), .analog_monitor_output_o(mon), .quick_start_o(qs),
        .in_func_o(in_func), .out_func_o(out_func), .status_o(st),
        .serial_cfg_o(scfg));
    net_master_model mst (.clk_sys_i(clk_sys_i), .net_req_o(req),
        .net_rsp_i(rsp));

    // 50 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task report_and_stop;
        if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // value compare
    task chk(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // one network access with expected answer code and data
    task acc(input logic w, input w_type a, d, input logic [7:0] ee,
             input w_type er);
        mst.xfer(w, a, d, exc, rd, tmo);
        chk("exc", {8'h00, ee}, {8'h00, exc});
        if (ee == 8'h00) chk("rdata", er, rd);
        if (tmo) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : acc

    // clock edges, inputs move 1 ns after the last one
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    // largest accepted value of a numeric register
    function automatic w_type lim(input int i);
        if (i == 18) return 16'h4e20;
        if (i == 19 || i == 20) return 16'h0fa0;
        if (i > 20) return 16'h03e8;
        if (i > 10 && i < 14) return 16'h0009;
        return 16'h0001;
    endfunction : lim

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_i = 1'b1;
        lwr = 1'b0;
        lsel = 3'h0;
        ldat = 16'h0000;
        in_pin = 5'h00;
        out_st = 3'h0;
        meas = '0;
        void'($urandom(32'h34b1));
        repeat (12) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        // reset values, random in-range writes, read back
        for (int i = 0; i < 24; i++) begin
            ha = term_bank_pkg::hold_addr[i];
            acc(0, ha, 0, 8'h00, 16'h0000);
            shadow[i] = (i > 0 && i < 6) ? fc[$urandom % 6] :
                        16'($urandom % (32'(lim(i)) + 1));
            acc(1, ha, shadow[i], 8'h00, shadow[i]);
        end
        // one above range or unlisted code 000a refused and value kept, range top accepted for numeric registers
        for (int i = 0; i < 24; i++) begin
            ha = term_bank_pkg::hold_addr[i];
            t = (i > 0 && i < 6) ? 16'h000a : lim(i) + 16'h0001;
            acc(1, ha, t, 8'h03, 0);
            acc(0, ha, 0, 8'h00, shadow[i]);
            if (i < 1 || i > 5) begin
                acc(1, ha, lim(i), 8'h00, lim(i));
            end
        end
        chk("in_func", shadow[1], in_func[0]);
        chk("out_func", 16'h0009, out_func[2]);
        // serial set and unmapped place refused on the network
        for (int a = 16'h1138; a < 16'h1141; a++) begin
            acc(0, 16'(a), 0, 8'h02, 0);
            acc(1, 16'(a), 16'h0001, 8'h02, 0);
        end
        // local edits of the serial set, select 7 ignored
        for (int s = 0; s < 8; s++) begin
            prev = scfg;
            lwr = 1'b1;
            lsel = 3'(s);
            ldat = 16'($urandom);
            cyc(1);
            lwr = 1'b0;
            cyc(1);
            if (s < 7) chk("serial", ldat, scfg[16*s +: 16]);
            else chk("serial", prev[15:0], scfg[15:0]);
        end
        // quick start, polarities, monitor source per code
        for (int p = 0; p < 2; p++) begin
            acc(1, 16'h10f9, 16'(p), 8'h00, 16'(p));
            chk("quick", 16'(p), {15'h0000, qs});
            for (int i = 6; i < 18; i++) begin
                if (i < 11 || i > 14) begin
                    ha = term_bank_pkg::hold_addr[i];
                    acc(1, ha, 16'(p), 8'h00, 16'(p));
                end
            end
            acc(1, 16'h111b, 16'(p), 8'h00, 16'(p));
            in_pin = 5'($urandom);
            out_st = 3'($urandom);
            meas.speed = 16'($urandom);
            meas.current = 16'($urandom);
            cyc(1);
            t = {13'h0000, out_st ^ {3{p[0]}}};
            chk("out_pin", t, {13'h0000, out_pin});
            chk("monitor", p ? meas.current : meas.speed, mon);
            cyc(2);
            t = {11'h000, in_pin ^ {5{p[0]}}};
            chk("in_act", t, {11'h000, in_act});
        end
        // overload at rated current and at a random level
        for (int k = 0; k < 2; k++) begin
            t = k ? 16'($urandom % 20000) : 16'h2710;
            acc(1, 16'h1124, t, 8'h00, t);
            meas.current = t;
            cyc(1);
            chk("overload", 16'h0000, {15'h0000, st.overload});
            meas.current = t + 16'h0001;
            cyc(1);
            chk("overload", 16'h0001, {15'h0000, st.overload});
        end
        // arrival thresholds while accelerating and decelerating
        t = 16'(1 + $urandom % 3999);
        acc(1, 16'h1126, t, 8'h00, t);
        acc(1, 16'h1128, t, 8'h00, t);
        meas.freq = t;
        meas.accel = 1'b1;
        cyc(1);
        chk("accel", 16'h0001, {15'h0000, st.accel_arrive});
        meas.freq = t - 16'h0001;
        meas.accel = 1'b0;
        meas.decel = 1'b1;
        cyc(1);
        chk("decel", 16'h0001, {15'h0000, st.decel_arrive});
        chk("accel", 16'h0000, {15'h0000, st.accel_arrive});
        meas.freq = t + 16'h0001;
        cyc(1);
        chk("decel", 16'h0000, {15'h0000, st.decel_arrive});
        // deviation magnitude on both sides of the setpoint
        t = 16'($urandom % 1001);
        acc(1, 16'h1129, t, 8'h00, t);
        meas.setpoint = 16'h0800;
        meas.feedback = 16'h0800 + t;
        cyc(1);
        chk("dev", 16'h0000, {15'h0000, st.deviation});
        meas.feedback = 16'h07ff - t;
        cyc(1);
        chk("dev", 16'h0001, {15'h0000, st.deviation});
        // second stage window: set below lower, hold, clear above upper
        acc(1, 16'h112e, 16'h0258, 8'h00, 16'h0258);
        acc(1, 16'h112f, 16'h0190, 8'h00, 16'h0190);
        meas.feedback = 16'h018f;
        cyc(2);
        chk("stage2", 16'h0001, {15'h0000, st.stage2});
        meas.feedback = 16'h01f4;
        cyc(2);
        chk("stage2", 16'h0001, {15'h0000, st.stage2});
        meas.feedback = 16'h0259;
        cyc(2);
        chk("stage2", 16'h0000, {15'h0000, st.stage2});
        report_and_stop();
    end
endmodule : terminal_function_holding_regs_tb_top
